// File: rtl/acquisition_sample_memory_addr.sv
// sample memory, write/read addressing and slot interface of the digitizer board
`timescale 1ns/1ps
`default_nettype none
module acquisition_sample_memory_addr (
    input  wire logic        mclk,              // 50 MHz system clock
    input  wire logic        rst,               // async reset, active high
    input  wire logic        master_clock,      // converter master clock level
    input  wire logic        sample_mem_clock_a,// memory clock for low half
    input  wire logic        sample_mem_clock_b,// memory clock for high half
    input  wire logic        acquisition_gate,  // high while storing
    input  wire logic        triggerSeen,       // trigger has occurred
    input  wire logic [7:0]  converterWord,     // converter output byte
    input  wire logic        busStrobe,         // host bus cycle request
    input  wire logic        busRead,           // host cycle is a read
    input  wire logic        boardTypeReq,      // host asks for board type
    input  wire logic [22:0] busAddr,           // host bus address
    input  wire logic [3:0]  slot_identity,     // slot code of this board
    output logic      [7:0]  busData,           // data returned to host
    output logic             busDataOe,         // low while driving data lines
    output logic             bus_acknowledge_n, // cycle acknowledge, low active
    output logic             read_cycle_enable_n, // read enable, low active
    output logic             local_write_side_enable, // write side enable
    output logic      [3:0]  phase_clocks,      // capture latch load pulses
    output logic             lane_write_strobe_a_n, // low half write strobe
    output logic             lane_write_strobe_b_n, // high half write strobe
    output logic             address_step_clock,    // address step enable
    output logic      [7:0]  ramAddr,           // local ram address bus
    output logic      [7:0]  writeAddr          // registered write address
);
    typedef struct packed {
        logic [1:0]  phase;
        logic [31:0] capWord;
        logic [3:0]  laneFresh;
        logic [7:0]  addrCnt;
        logic [7:0]  addrLatch;
        logic        stopped;
        logic        cycleHit;
        logic        readEn;
        logic        writeEn;
        logic [7:0]  dataOut;
        logic        dataOe;
        logic [3:0]  pclk;
        logic        weA;
        logic        weB;
        logic        step;
        logic        mclkPrev;
    } top_state_t;
    top_state_t stateReg;
    top_state_t stateNext;

    // eight narrow devices, one nibble each; a word of lanes spans all eight
    logic [acq_mem_pkg::NIBBLE_W-1:0] ram [acq_mem_pkg::DEVICES][acq_mem_pkg::DEPTH];

    logic        fifoInValid;
    logic        fifoInReady;
    logic        fifoOutValid;
    logic        fifoOutReady;
    logic [31:0] fifoOutData;
    logic [7:0]  readAddr;
    logic        slotMatch;
    logic        storing;

    function automatic logic [3:0] phase_onehot(input logic [1:0] p);
        phase_onehot = 4'h1 << p;
    endfunction

    assign slotMatch = busAddr[acq_mem_pkg::SLOT_HI:acq_mem_pkg::SLOT_LO] == slot_identity;
    // read address wraps naturally in eight bits
    assign readAddr = stateReg.addrCnt
                    + busAddr[acq_mem_pkg::OFFS_HI:acq_mem_pkg::OFFS_LO];
    assign storing  = acquisition_gate && !stateReg.stopped;
    assign fifoInValid  = storing && (stateReg.laneFresh == 4'hf);
    // memory writes happen only on the address step, so drain then
    assign fifoOutReady = stateReg.step;

    sample_fifo #(
        .WIDTH(acq_mem_pkg::WORD_W),
        .DEPTH(acq_mem_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk    (mclk),
        .rst     (rst),
        .inValid (fifoInValid),
        .inReady (fifoInReady),
        .inData  (stateReg.capWord),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData (fifoOutData)
    );

    always_comb begin
        stateNext = stateReg;
        stateNext.mclkPrev = master_clock;
        stateNext.pclk = 4'h0;
        stateNext.weA  = 1'b0;
        stateNext.weB  = 1'b0;
        stateNext.step = 1'b0;
        // each rising master clock edge advances one quarter phase
        if (master_clock && !stateReg.mclkPrev) begin
            stateNext.phase = stateReg.phase + 2'h1;
            stateNext.pclk  = phase_onehot(stateReg.phase);
        end
        // latch loads one byte lane per phase, lanes valid at staggered times
        for (int i = 0; i < acq_mem_pkg::LANES; i++) begin
            if (stateReg.pclk[i] && storing) begin
                stateNext.capWord[i*8 +: 8] = converterWord;
                stateNext.laneFresh[i]      = 1'b1;
            end
        end
        if (fifoInValid && fifoInReady) begin
            stateNext.laneFresh = 4'h0;
        end
        // strobes follow their memory clocks only while a word is waiting
        if (fifoOutValid) begin
            stateNext.weA = sample_mem_clock_a;
            stateNext.weB = sample_mem_clock_b;
            // no step on the cycle after a step: the fifo has not yet shown whether a word is left
            stateNext.step = stateReg.weA && stateReg.weB && !stateReg.step;
        end
        if (stateReg.step) begin
            stateNext.addrCnt   = stateReg.addrCnt + 8'h01;
            stateNext.addrLatch = stateReg.addrCnt;
        end
        // counter simply holds between acquisitions; only reset clears it
        if (acquisition_gate && triggerSeen) begin
            stateNext.stopped = 1'b1;
        end else if (!acquisition_gate) begin
            stateNext.stopped = 1'b0;
        end
        stateNext.cycleHit = busStrobe && slotMatch;
        stateNext.readEn   = busStrobe && slotMatch && busRead;
        stateNext.writeEn  = busStrobe && slotMatch && !busRead;
        stateNext.dataOe   = !(busStrobe && slotMatch && busRead);
        if (boardTypeReq) begin
            stateNext.dataOut = {4'h0, acq_mem_pkg::BOARD_TYPE};
        end else begin
            for (int d = 0; d < acq_mem_pkg::DEVICES; d++) begin
                if (d < 2) begin
                    stateNext.dataOut[d*4 +: 4] = ram[d][readAddr];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateReg          <= '0;
            stateReg.phase    <= acq_mem_pkg::PHASE_RESET;
            stateReg.addrCnt  <= acq_mem_pkg::ADDR_RESET;
            stateReg.dataOe   <= 1'b1;
        end else begin
            stateReg <= stateNext;
        end
    end

    // all eight devices written together on the address step; each byte lane to its device pair
    generate
        for (genvar g = 0; g < acq_mem_pkg::DEVICES; g++) begin : g_dev
            always_ff @(posedge mclk) begin
                if (stateReg.step) begin
                    ram[g][stateReg.addrCnt] <= fifoOutData[g*4 +: 4];
                end
            end
        end
    endgenerate

    assign busData                 = stateReg.dataOut;
    assign busDataOe               = stateReg.dataOe;
    assign bus_acknowledge_n       = !stateReg.cycleHit;
    assign read_cycle_enable_n     = !stateReg.readEn;
    assign local_write_side_enable = stateReg.writeEn;
    assign phase_clocks            = stateReg.pclk;
    assign lane_write_strobe_a_n   = !stateReg.weA;
    assign lane_write_strobe_b_n   = !stateReg.weB;
    assign address_step_clock      = stateReg.step;
    assign writeAddr               = stateReg.addrLatch;
    // ram address mux: read path while reading, write latch during write cycles
    assign ramAddr = !stateReg.readEn ? (stateReg.writeEn ? stateReg.addrLatch : 8'h00)
                                      : readAddr;
endmodule
`default_nettype wire

// File: rtl/acq_mem_pkg.sv
// constants shared by the sample memory and addressing block
package acq_mem_pkg;
    localparam int ADDR_W      = 8;
    localparam int NIBBLE_W    = 4;
    localparam int LANE_W      = 8;
    localparam int LANES       = 4;
    localparam int DEVICES     = 8;
    localparam int WORD_W      = 32;
    localparam int HALF_W      = 16;
    localparam int DEPTH       = 256;
    localparam int FIFO_DEPTH  = 4;
    localparam int PHASE_COUNT = 4;
    localparam int OFFS_LO     = 3;
    localparam int OFFS_HI     = 10;
    localparam int SLOT_LO     = 19;
    localparam int SLOT_HI     = 22;
    localparam int BUS_ADDR_W  = 23;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [7:0] ADDR_RESET  = 8'h00;
    // board type code; value arbitrary
    localparam logic [3:0] BOARD_TYPE  = 4'h5;
endpackage

// File: rtl/sample_fifo.sv
// small valid/ready fifo for captured words
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,     // clock
    input  wire logic             rst,      // async reset
    input  wire logic             inValid,  // write request
    output logic                  inReady,  // room available
    input  wire logic [WIDTH-1:0] inData,   // write data
    output logic                  outValid, // data available
    input  wire logic             outReady, // drain accepts
    output logic      [WIDTH-1:0] outData   // head word
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0]   cnt;
    } fifo_state_t;
    fifo_state_t stateReg;
    fifo_state_t stateNext;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign inReady  = stateReg.cnt != (PW+1)'(DEPTH);
    assign outValid = stateReg.cnt != '0;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[stateReg.rp];
    always_comb begin
        stateNext = stateReg;
        if (push) begin
            stateNext.wp = stateReg.wp + 1'b1;
        end
        if (pop) begin
            stateNext.rp = stateReg.rp + 1'b1;
        end
        stateNext.cnt = stateReg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[stateReg.wp] <= inData;
        end
    end
endmodule
`default_nettype wire

// File: verif/acquisition_sample_memory_addr_sva.sv
// assertions on the host bus cycle and capture timing of the sample memory block
`timescale 1ns/1ps
`default_nettype none
module acquisition_sample_memory_addr_chk (
    input wire logic        mclk,                    // clock
    input wire logic        rst,                     // async reset
    input wire logic        busStrobe,               // cycle request
    input wire logic        busRead,                 // read flag
    input wire logic        boardTypeReq,            // type request
    input wire logic [22:0] busAddr,                 // host address
    input wire logic [3:0]  slot_identity,           // slot code
    input wire logic [7:0]  busData,                 // returned data
    input wire logic        busDataOe,               // data drive, low active
    input wire logic        bus_acknowledge_n,       // acknowledge
    input wire logic        read_cycle_enable_n,     // read enable
    input wire logic        local_write_side_enable, // write side enable
    input wire logic [3:0]  phase_clocks,            // latch pulses
    input wire logic        address_step_clock,      // step pulse
    input wire logic [7:0]  writeAddr,               // write address
    input wire logic [7:0]  ramAddr,                 // local ram address
    input wire logic        lane_write_strobe_a_n,   // low half strobe
    input wire logic        lane_write_strobe_b_n    // high half strobe
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire logic hit = busStrobe && busAddr[22:19] == slot_identity;
    chk_ack_on_match: assert property (bus_acknowledge_n == !$past(hit))
        else $error("acknowledge does not follow the slot match");
    chk_read_enable: assert property (read_cycle_enable_n == !$past(hit && busRead))
        else $error("read enable does not follow a matched read");
    chk_write_side: assert property (local_write_side_enable == $past(hit && !busRead))
        else $error("write side enable without a matched write cycle");
    chk_type_code: assert property (hit && boardTypeReq |=> busData == {4'h0, acq_mem_pkg::BOARD_TYPE})
        else $error("board type code wrong");
    chk_drive_read: assert property (!busDataOe |-> $past(hit && busRead))
        else $error("data lines driven outside a matched read");
    chk_phase_onehot: assert property ($onehot0(phase_clocks))
        else $error("phase pulses overlap");
    chk_phase_pulse: assert property (|phase_clocks |=> phase_clocks == 4'h0)
        else $error("phase pulse longer than one cycle");
    chk_addr_hold: assert property ($changed(writeAddr) |-> address_step_clock || $past(address_step_clock))
        else $error("write address moved without a step");
    chk_addr_step: assert property ($changed(writeAddr) |-> writeAddr == 8'($past(writeAddr) + 8'h01))
        else $error("write address did not advance by one");
    chk_ram_idle: assert property (read_cycle_enable_n && !local_write_side_enable |-> ramAddr == 8'h00)
        else $error("ram address driven outside a bus cycle");
    chk_ram_write: assert property (local_write_side_enable |-> ramAddr == writeAddr)
        else $error("write cycle does not show the write address");
    chk_strobe_step: assert property (address_step_clock |-> $past(!lane_write_strobe_a_n && !lane_write_strobe_b_n))
        else $error("address step without both write strobes");
    chk_step_single: assert property (address_step_clock |=> !address_step_clock)
        else $error("address step longer than one cycle");
endmodule
bind acquisition_sample_memory_addr acquisition_sample_memory_addr_chk chk (
    .mclk(mclk), .rst(rst), .busStrobe(busStrobe), .busRead(busRead),
    .boardTypeReq(boardTypeReq), .busAddr(busAddr), .slot_identity(slot_identity),
    .busData(busData), .busDataOe(busDataOe), .bus_acknowledge_n(bus_acknowledge_n),
    .read_cycle_enable_n(read_cycle_enable_n), .local_write_side_enable(local_write_side_enable),
    .phase_clocks(phase_clocks), .address_step_clock(address_step_clock), .writeAddr(writeAddr),
    .ramAddr(ramAddr), .lane_write_strobe_a_n(lane_write_strobe_a_n),
    .lane_write_strobe_b_n(lane_write_strobe_b_n));
`default_nettype wire

// File: verif/host_bus_model.sv
// host side of the slotted bus: issues read cycles and collects the answer
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic        mclk,              // clock
    output logic             busStrobe,         // cycle request
    output logic             busRead,           // read flag
    output logic             boardTypeReq,      // board type request
    output logic      [22:0] busAddr,           // address
    input  wire logic        bus_acknowledge_n, // acknowledge, low active
    input  wire logic [7:0]  busData            // returned data
);
    initial begin
        busStrobe = 1'b0;
        busRead = 1'b1;
        boardTypeReq = 1'b0;
        busAddr = 23'h000000;
    end
    // request held until acknowledge is sampled low; a refused cycle gives up after 6 edges
    task automatic cycle(input logic [22:0] addr, input logic typeReq,
                         output logic [7:0] data, output logic acked);
        int i;
        @(posedge mclk);
        #1;
        busStrobe = 1'b1;
        busAddr = addr;
        boardTypeReq = typeReq;
        acked = 1'b0;
        data = 8'h00;
        for (i = 0; i < 6 && !acked; i++) begin
            @(posedge mclk);
            #1;
            if (bus_acknowledge_n === 1'b0) begin
                acked = 1'b1;
                data = busData;
            end
        end
        #1;
        busStrobe = 1'b0;
        boardTypeReq = 1'b0;
        busAddr = ~addr; // released lines do not keep their last value
    endtask
endmodule
`default_nettype wire

// File: verif/acquisition_sample_memory_addr_tb.sv
// self-checking bench: acquisitions with stalls and trigger, then host reads back
`timescale 1ns/1ps
`default_nettype none
module acquisition_sample_memory_addr_tb;
    localparam logic [3:0] SLOT = 4'ha;
    logic mclk, rst, master_clock, smcA, smcB, gate, trig, memHold;
    logic [7:0] convWord, wrPtr, d;
    logic [7:0] expMem [256];
    logic [31:0] lfsr, memRnd;
    logic busStrobe, busRead, boardTypeReq, ackN, ok;
    logic [22:0] busAddr;
    logic [7:0] busData;
    int miscompares, n_checks, i;
    acquisition_sample_memory_addr dut (.mclk(mclk), .rst(rst), .master_clock(master_clock),
        .sample_mem_clock_a(smcA), .sample_mem_clock_b(smcB), .acquisition_gate(gate),
        .triggerSeen(trig), .converterWord(convWord), .busStrobe(busStrobe), .busRead(busRead),
        .boardTypeReq(boardTypeReq), .busAddr(busAddr), .slot_identity(SLOT), .busData(busData),
        .busDataOe(), .bus_acknowledge_n(ackN), .read_cycle_enable_n(),
        .local_write_side_enable(), .phase_clocks(), .lane_write_strobe_a_n(),
        .lane_write_strobe_b_n(), .address_step_clock(), .ramAddr(), .writeAddr());
    host_bus_model host (.mclk(mclk), .busStrobe(busStrobe), .busRead(busRead),
        .boardTypeReq(boardTypeReq), .busAddr(busAddr), .bus_acknowledge_n(ackN), .busData(busData));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one byte held over all four phase steps, so lane order does not matter for lane 0
    task automatic feed_word(input logic [7:0] b);
        int k;
        convWord = b;
        for (k = 0; k < 8; k++) begin
            master_clock = ~master_clock;
            repeat (3) @(posedge mclk);
            #1;
        end
    endtask
    task automatic acquire(input int n, input int stall);
        int k;
        gate = 1'b1;
        for (k = 0; k < n + 2; k++) begin
            memHold = k < stall;
            trig = k >= n;
            lfsr = next_rand(lfsr);
            feed_word(lfsr[7:0]);
            if (k < n) begin
                expMem[wrPtr] = lfsr[7:0];
                wrPtr++;
            end
            if (k == n - 1) begin
                repeat (60) @(posedge mclk);
                #1;
            end
        end
        repeat (40) @(posedge mclk);
        #1;
        gate = 1'b0;
        trig = 1'b0;
    endtask
    task automatic read_check(input logic [7:0] idx);
        lfsr = next_rand(lfsr);
        host.cycle({SLOT, lfsr[7:0], 8'(idx - wrPtr), lfsr[10:8]}, 1'b0, d, ok);
        check({7'h0, ok}, 8'h01);
        check(d, expMem[idx]);
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // memory clocks come from their own sequence so the main flow stays repeatable
    always @(posedge mclk) begin
        #1;
        memRnd = next_rand(memRnd);
        {smcA, smcB} = memHold ? 2'b00 : memRnd[1:0];
    end
    initial begin
        repeat (50000) @(posedge mclk);
        miscompares++;
        end_of_test;
    end
    initial begin
        {rst, master_clock, gate, trig, memHold, convWord, wrPtr} = {5'b10000, 16'h0000};
        {lfsr, memRnd} = {2{32'hf7d7893f}};
        miscompares = 0;
        n_checks = 0;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        host.cycle({SLOT, 19'h00000}, 1'b1, d, ok);
        check(d, {4'h0, acq_mem_pkg::BOARD_TYPE});
        host.cycle({SLOT ^ 4'h1, 19'h00008}, 1'b0, d, ok);
        check({7'h0, ok}, 8'h00);
        acquire(6, 3);
        for (i = 0; i < 6; i++) begin
            read_check(8'(i));
        end
        acquire(3, 0);
        for (i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            read_check(8'(lfsr[15:0] % 16'(wrPtr)));
        end
        end_of_test;
    end
endmodule
`default_nettype wire
